//--- shared/sar_pkg.sv
`default_nettype none

package sar_pkg;

  // ==========================================================================
  // Sizes and counts
  localparam int         RES_BITS   = 12;
  localparam logic [3:0] CNT_RESET  = 4'h0;
  localparam logic [3:0] CONV_LAST  = 4'hb;
  localparam logic [3:0] LSBF_FIRST = 4'h1;
  localparam logic [3:0] LSBF_LAST  = 4'hb;

  // ==========================================================================
  // Pin levels
  localparam logic NULL_BIT  = 1'b0;
  localparam logic DOUT_REST = 1'b0;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ARMED = 6'h02,
    ST_NULL  = 6'h04,
    ST_CONV  = 6'h08,
    ST_LSBF  = 6'h10,
    ST_DONE  = 6'h20
  } sar_state_t;

  // Front-end controls that travel together
  typedef struct packed {
    logic cap_to_pos;
    logic hold;
    logic dout;
    logic dout_oe;
  } sar_front_t;

  localparam sar_front_t FRONT_RESET = '{cap_to_pos: 1'b1, hold: 1'b0,
                                         dout: 1'b0, dout_oe: 1'b0};

endpackage

`default_nettype wire

//--- verilog/sar_engine.sv
`default_nettype none

module sar_engine #(
  parameter int WIDTH = sar_pkg::RES_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             clr,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             cmp_hi,
  // Results
  output logic      [WIDTH-1:0] trial,
  output logic      [WIDTH-1:0] result
);

  localparam int IW = $clog2(WIDTH);
  localparam logic [IW-1:0] TOP_IDX = IW'(WIDTH - 1);

  logic [WIDTH-1:0] trial_q, trial_d;
  logic [WIDTH-1:0] result_q, result_d;
  logic [IW-1:0]    idx_q, idx_d;

  function automatic logic [WIDTH-1:0] one_hot(input logic [IW-1:0] i);
    logic [WIDTH-1:0] v;
    v    = '0;
    v[i] = 1'b1;
    return v;
  endfunction

  // ==========================================================================
  // Successive approximation, one decision per step
  always_comb begin
    logic [WIDTH-1:0] r;
    r        = result_q;
    trial_d  = trial_q;
    result_d = result_q;
    idx_d    = idx_q;
    if (clr) begin
      trial_d  = '0;
      result_d = '0;
      idx_d    = TOP_IDX;
    end else if (start) begin
      trial_d  = one_hot(TOP_IDX);
      result_d = '0;
      idx_d    = TOP_IDX;
    end else if (step) begin
      r[idx_q] = cmp_hi;
      result_d = r;
      if (idx_q != '0) begin
        idx_d   = idx_q - 1'b1;
        trial_d = r | one_hot(idx_q - 1'b1);
      end else begin
        trial_d = r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q  <= '0;
      result_q <= '0;
      idx_q    <= TOP_IDX;
    end else begin
      trial_q  <= trial_d;
      result_q <= result_d;
      idx_q    <= idx_d;
    end
  end

  assign trial  = trial_q;
  assign result = result_q;

endmodule

`default_nettype wire

//--- verilog/sar_readout.sv
`default_nettype none

module sar_readout (
  // System clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          RSTN,
  // Host serial pins
  input  wire logic                          SEL_N,
  input  wire logic                          SCLK,
  output logic                               DOUT,
  output logic                               DOUT_OE,
  // Analog front end
  input  wire logic                          CMP_IN,
  output logic                               CAP_TO_POS,
  output logic                               HOLD,
  output logic [sar_pkg::RES_BITS-1:0]       DAC_CODE
);

  // ==========================================================================
  // Shift clock edge detection
  // Pins are synchronous to CLK_SYS, so one stage is enough for edges
  logic sclk_q;
  logic sclk_rise, sclk_fall;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= SCLK;
    end
  end

  assign sclk_rise = SCLK & ~sclk_q;
  assign sclk_fall = ~SCLK & sclk_q;

  // ==========================================================================
  // Sequencer
  sar_pkg::sar_state_t          state_q, state_d;
  sar_pkg::sar_front_t          front_q, front_d;
  logic [3:0]                   cnt_q, cnt_d;
  logic                         eng_start, eng_step;
  logic [sar_pkg::RES_BITS-1:0] res;
  logic [sar_pkg::RES_BITS-1:0] trial;

  always_comb begin
    state_d   = state_q;
    front_d   = front_q;
    cnt_d     = cnt_q;
    eng_start = 1'b0;
    eng_step  = 1'b0;
    if (SEL_N) begin
      // Select high clears everything and keeps sampling
      state_d = sar_pkg::ST_IDLE;
      front_d = sar_pkg::FRONT_RESET;
      cnt_d   = sar_pkg::CNT_RESET;
    end else begin
      case (state_q)
        sar_pkg::ST_IDLE: begin
          state_d = sar_pkg::ST_ARMED;
        end
        sar_pkg::ST_ARMED: begin
          if (sclk_rise) begin
            front_d.dout_oe = 1'b1;
            front_d.dout    = sar_pkg::NULL_BIT;
            state_d         = sar_pkg::ST_NULL;
          end
        end
        sar_pkg::ST_NULL: begin
          if (sclk_fall) begin
            // Sampling ends here; the one switch to the negative input
            front_d.hold       = 1'b1;
            front_d.cap_to_pos = 1'b0;
            front_d.dout       = sar_pkg::NULL_BIT;
            eng_start          = 1'b1;
            cnt_d              = sar_pkg::CNT_RESET;
            state_d            = sar_pkg::ST_CONV;
          end
        end
        sar_pkg::ST_CONV: begin
          if (sclk_fall) begin
            // Each decided bit leaves at once, MSB first
            eng_step     = 1'b1;
            front_d.dout = CMP_IN;
            if (cnt_q == sar_pkg::CONV_LAST) begin
              cnt_d   = sar_pkg::LSBF_FIRST;
              state_d = sar_pkg::ST_LSBF;
            end else begin
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        sar_pkg::ST_LSBF: begin
          if (sclk_fall) begin
            front_d.dout = res[cnt_q];
            if (cnt_q == sar_pkg::LSBF_LAST) begin
              state_d = sar_pkg::ST_DONE;
            end else begin
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        sar_pkg::ST_DONE: begin
          if (sclk_fall) begin
            front_d.dout = sar_pkg::DOUT_REST;
          end
        end
        default: begin
          state_d = sar_pkg::ST_IDLE;
          front_d = sar_pkg::FRONT_RESET;
          cnt_d   = sar_pkg::CNT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= sar_pkg::ST_IDLE;
      front_q <= sar_pkg::FRONT_RESET;
      cnt_q   <= sar_pkg::CNT_RESET;
    end else begin
      state_q <= state_d;
      front_q <= front_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================================
  // Converter core: fixed unipolar straight binary, no channel choice
  sar_engine #(
    .WIDTH (sar_pkg::RES_BITS)
  ) u_engine (
    .clk    (CLK_SYS),
    .rst_n  (RSTN),
    .clr    (SEL_N),
    .start  (eng_start),
    .step   (eng_step),
    .cmp_hi (CMP_IN),
    .trial  (trial),
    .result (res)
  );

  assign DOUT       = front_q.dout;
  assign DOUT_OE    = front_q.dout_oe;
  assign CAP_TO_POS = front_q.cap_to_pos;
  assign HOLD       = front_q.hold;
  assign DAC_CODE   = trial;

endmodule

`default_nettype wire

//--- sim/sar_front_model.sv
`default_nettype none

module sar_front_model (
  // Front end
  input  wire logic                         CLK_SYS,
  input  wire logic [sar_pkg::RES_BITS-1:0] vin,
  input  wire logic [sar_pkg::RES_BITS-1:0] DAC_CODE,
  input  wire logic                         HOLD,
  output logic                              CMP_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [sar_pkg::RES_BITS-1:0] held_q;
  always_ff @(posedge CLK_SYS)
    if (!HOLD) held_q <= vin;
  // Toggles outside hold so a stray read is seen
  assign CMP_IN = HOLD ? (held_q >= DAC_CODE) : CLK_SYS;
endmodule

`default_nettype wire

//--- sim/sar_readout_properties.sv
`default_nettype none

module sar_readout_properties (
  // Pins of the block
  input wire logic                         CLK_SYS,
  input wire logic                         RSTN,
  input wire logic                         SEL_N,
  input wire logic                         SCLK,
  input wire logic                         DOUT,
  input wire logic                         DOUT_OE,
  input wire logic                         CAP_TO_POS,
  input wire logic                         HOLD,
  input wire logic [sar_pkg::RES_BITS-1:0] DAC_CODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence s_armed_rise;
    !SEL_N && !$past(SEL_N) && !$past(SEL_N, 2) && $rose(SCLK);
  endsequence
  sequence s_first_fall;
    !SEL_N && DOUT_OE && !HOLD && $fell(SCLK);
  endsequence
  a_idle_float: assert property (SEL_N |=> !DOUT_OE)
    else $error("output enabled while deselected");
  a_seq_reset: assert property (SEL_N ##1 SEL_N |-> !HOLD && !DOUT
    && CAP_TO_POS && DAC_CODE == 12'h000)
    else $error("sequencer not idle while deselected");
  a_oe_wait: assert property (!SEL_N && !SCLK && !DOUT_OE |=> !DOUT_OE)
    else $error("output enabled before a shift clock");
  a_oe_on_rise: assert property (s_armed_rise |-> ##[1:3] DOUT_OE)
    else $error("output not enabled by first shift clock");
  a_hold_start: assert property (s_first_fall |-> ##[1:3] HOLD)
    else $error("hold not entered on first falling clock");
  a_cap_sample: assert property (!HOLD |-> CAP_TO_POS)
    else $error("capacitor off positive input while sampling");
  a_cap_once: assert property (!CAP_TO_POS && !SEL_N |=> !CAP_TO_POS)
    else $error("capacitor switched back within a cycle");
  a_dout_steady: assert property (!SEL_N && SCLK && $past(SCLK)
    && $past(SCLK, 2) |-> $stable(DOUT))
    else $error("serial output moved while clock high");
  a_dac_first: assert property ($rose(HOLD) |-> DAC_CODE == 12'h800)
    else $error("first trial code is not half scale");
endmodule

bind sar_readout sar_readout_properties chk (.CLK_SYS(CLK_SYS),
  .RSTN(RSTN), .SEL_N(SEL_N), .SCLK(SCLK), .DOUT(DOUT),
  .DOUT_OE(DOUT_OE), .CAP_TO_POS(CAP_TO_POS), .HOLD(HOLD),
  .DAC_CODE(DAC_CODE));

`default_nettype wire

//--- sim/sar_readout_tb.sv
`default_nettype none

module sar_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS = 1'b0;
  logic        RSTN    = 1'b0;
  logic        SEL_N   = 1'b1;
  logic        SCLK    = 1'b0;
  logic        CMP_IN, DOUT, DOUT_OE, CAP_TO_POS, HOLD;
  logic [11:0] DAC_CODE;
  logic [11:0] vin     = 12'h000;
  logic [25:0] got;
  int          num_errors  = 0;
  int          check_count = 0;
  // Select-high gap of 5.0 us at a 5 ns clock
  localparam int GAP_CYC = 1000;
  always #2.5 CLK_SYS = ~CLK_SYS;
  sar_readout dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .SEL_N(SEL_N),
    .SCLK(SCLK), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .CMP_IN(CMP_IN),
    .CAP_TO_POS(CAP_TO_POS), .HOLD(HOLD), .DAC_CODE(DAC_CODE));
  sar_front_model fe (.CLK_SYS(CLK_SYS), .vin(vin), .DAC_CODE(DAC_CODE),
    .HOLD(HOLD), .CMP_IN(CMP_IN));
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t bit %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_code(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t word %h exp %h", $time, g, e);
    end
  endtask
  // ==========================================================
  // One select-low cycle; DOUT sampled late in each high phase
  task automatic xfer(input logic [11:0] v, input int n);
    @(posedge CLK_SYS) vin <= v;
    SEL_N <= 1'b0;
    cyc(2);
    #1 chk_bit(DOUT_OE, 1'b0);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_SYS) SCLK <= 1'b1;
      cyc(3);
      #1 got[i] = DOUT;
      chk_bit(DOUT_OE, 1'b1);
      if (i < 2) chk_bit(HOLD, i[0]);
      if (i < 2) chk_bit(CAP_TO_POS, !i[0]);
      @(posedge CLK_SYS) SCLK <= 1'b0;
      cyc(3);
    end
    @(posedge CLK_SYS) SEL_N <= 1'b1;
    cyc(3);
    #1 chk_bit(DOUT_OE, 1'b0);
    chk_bit(HOLD, 1'b0);
    cyc(GAP_CYC);
  endtask
  task automatic t_full(input logic [11:0] v);
    logic [11:0] msb;
    logic [11:0] lsb;
    xfer(v, 26);
    for (int k = 0; k < 12; k++) begin
      msb[11-k] = got[2+k];
      lsb[k] = (k == 0) ? 1'b0 : got[13+k];
    end
    chk_code(msb, v);
    chk_code(lsb, {v[11:1], 1'b0});
    chk_bit(got[0] | got[1] | got[25], 1'b0);
  endtask
  // Abort in the LSB-first readout, clock while deselected, then a fresh value
  task automatic t_abort();
    logic [11:0] msb;
    xfer(12'h3c3, 14);
    for (int k = 0; k < 12; k++) begin
      msb[11-k] = got[2+k];
    end
    chk_code(msb, 12'h3c3);
    @(posedge CLK_SYS) SCLK <= 1'b1;
    cyc(3);
    #1 chk_bit(DOUT_OE, 1'b0);
    @(posedge CLK_SYS) SCLK <= 1'b0;
    t_full(12'h5a6);
  endtask
  task automatic t_reset();
    cyc(16);
    #1 chk_bit(CAP_TO_POS, 1'b1);
    chk_code(DAC_CODE, 12'h000);
    @(posedge CLK_SYS) RSTN <= 1'b1;
    cyc(2);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_full(12'h000);
    t_full(12'hfff);
    t_full(12'h801);
    t_full(12'ha5c);
    t_abort();
    summarize();
  end
endmodule

`default_nettype wire
